// ### src/ddc_regs.svh
// constants for the ddr3 command decoder
`ifndef DDC_REGS_SVH
`define DDC_REGS_SVH
`define DDC_BANKS 8
`define DDC_BA_W 3
`define DDC_ADDR_W 16
`define DDC_DQ_W 8
`define DDC_AP_BIT 10
`define DDC_BC_BIT 12
`define DDC_BL8_BEATS 8
`define DDC_BC4_BEATS 4
// register offsets (bytes)
`define DDC_REG_STATUS 12'h000
`define DDC_REG_BANKS 12'h004
`define DDC_REG_LASTCMD 12'h008
`define DDC_REG_MR0 12'h010
`define DDC_REG_MR1 12'h014
`define DDC_REG_MR2 12'h018
`define DDC_REG_MR3 12'h01c
`define DDC_REG_CTRL 12'h020
`define DDC_REG_WDATA 12'h024
`define DDC_REG_WCOUNT 12'h028
// mode register field positions
`define DDC_MR0_BL_LSB 0
`define DDC_MR1_TDQS_BIT 11
`define DDC_MR1_RTT0 2
`define DDC_MR1_RTT1 6
`define DDC_MR1_RTT2 9
`define DDC_MR2_RTTWR_LSB 9
// ctrl register reset value
`define DDC_CTRL_RST 32'h0000_0000
`endif

// ### src/ddc_pkg.sv
// types for the ddr3 command decoder
package ddc_pkg;
  typedef enum logic [3:0] {
    DDC_CMD_DES, DDC_CMD_NOP, DDC_CMD_ACT, DDC_CMD_PRE, DDC_CMD_PREA, DDC_CMD_WR,
    DDC_CMD_RD, DDC_CMD_MRS, DDC_CMD_REF, DDC_CMD_SRE, DDC_CMD_SRX, DDC_CMD_PDE,
    DDC_CMD_PDX, DDC_CMD_ZQL, DDC_CMD_ZQS, DDC_CMD_BST
  } ddc_cmd_t;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [2:0] ba;
    logic [15:0] a;
  } ddc_ca_t;
  typedef struct packed {
    ddc_cmd_t cmd;
    logic [2:0] ba;
    logic [15:0] a;
    logic ap;
    logic bl8;
  } ddc_dec_t;
endpackage

// ### src/ddc_sync.sv
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
module ddc_sync
  import ddc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;
  // refuse an empty bundle at elaboration
  if (WIDTH < 1)
  begin
    $error("ddc_sync width must be positive");
  end
  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      meta <= '0;
      dout <= '0;
    end
    else if (clk_en)
    begin
      meta <= din;
      dout <= meta;
    end
endmodule

// ### src/ddc_decode.sv
// combinational command decoder of ddr3 pin codes
`timescale 1ns/1ns
module ddc_decode
  import ddc_pkg::*;
(
  // sampled pins and state
  input wire ddc_ca_t ca,
  input wire logic cke_prev,
  input wire logic otf_en,
  input wire logic fixed_bl8,
  input wire logic bursting,
  // decoded command
  output ddc_dec_t dec
);
  `include "ddc_regs.svh"
  logic [2:0] code;
  assign code = {ca.ras_n, ca.cas_n, ca.we_n};
  // truth table decode
  always_comb
  begin
    dec.ba = ca.ba;
    dec.a = ca.a;
    dec.ap = ca.a[`DDC_AP_BIT];
    dec.bl8 = otf_en ? ca.a[`DDC_BC_BIT] : fixed_bl8;
    dec.cmd = DDC_CMD_NOP;
    if (!cke_prev)
    begin
      // exit only with nop or deselect
      if (ca.cke && (ca.cs_n || code == 3'h7)) dec.cmd = DDC_CMD_PDX;
      else dec.cmd = DDC_CMD_DES;
    end
    else if (ca.cs_n)
      dec.cmd = ca.cke ? DDC_CMD_DES : DDC_CMD_PDE;
    else if (code == 3'h7)
      dec.cmd = ca.cke ? DDC_CMD_NOP : DDC_CMD_PDE;
    else if (code == 3'h6 && bursting)
      dec.cmd = DDC_CMD_BST;
    else if (code == 3'h1 && !ca.cke)
      dec.cmd = DDC_CMD_SRE;
    else if (!ca.cke)
      dec.cmd = DDC_CMD_DES;
    else
    begin
      unique case (code)
        3'h3: dec.cmd = DDC_CMD_ACT;
        3'h2: dec.cmd = ca.a[`DDC_AP_BIT] ? DDC_CMD_PREA : DDC_CMD_PRE;
        3'h4: dec.cmd = DDC_CMD_WR;
        3'h5: dec.cmd = DDC_CMD_RD;
        3'h0: dec.cmd = DDC_CMD_MRS;
        3'h1: dec.cmd = DDC_CMD_REF;
        3'h6: dec.cmd = ca.a[`DDC_AP_BIT] ? DDC_CMD_ZQL : DDC_CMD_ZQS;
        3'h7: dec.cmd = DDC_CMD_NOP;
      endcase
    end
  end
endmodule

// ### src/ddc_top.sv
// ddr3 command decoder top with pin sampling, bank state, data path and ahb-lite
// Contract
// - cs high means deselect, no command
// - ras low, we high: bank activate; the decoder also needs cas high (cas low is refresh)
// - ras low, cas high, we low: precharge
// - commands need cke high both cycles; the decoder takes burst stop while bursting with cke low in the current cycle
// - all strobes low, idle: mode register load
// - write command to active bank, a10 autoprecharge
// - on-the-fly a12 low write is four beats
// - read command to active bank, a10 autoprecharge
// - on-the-fly a12 high read is eight beats
// - refresh with cke high, self-refresh when low
// - register cke, compare with previous level
// - cke falling with nop enters power-down
// - cke rising with nop or deselect exits
// - zq calibration idle, burst stop when bursting
// - mask high drops the write beat
// - data moves on both strobe edges
// - odt high turns on termination
// - mr1 a11 enables tdqs, disables mask
// - odt ignored when rtt disabled
// - reset pin resets asynchronously
`timescale 1ns/1ns
module ddc_top
  import ddc_pkg::*;
(
  // clock, enable, reset
  input wire logic clk_sys,
  input wire logic clk_en,
  input wire logic rst_n,
  // ddr3 pins
  input wire logic ck,
  input wire ddc_ca_t ca_pin,
  input wire logic odt,
  input wire logic dqs_in,
  input wire logic [7:0] dq_in,
  input wire logic dm_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  output logic dqs_out,
  output logic dqs_oe,
  output logic term_on,
  output logic tdqs_term,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  `include "ddc_regs.svh"
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  localparam int PW = $bits(ddc_ca_t) + 12;
  logic [PW-1:0] pin_s;
  ddc_ca_t ca;
  logic ck_s, odt_s, dqs_s, dm_s;
  logic [7:0] dq_s;
  ddc_sync #(.WIDTH(PW)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .din({ck, ca_pin, odt, dqs_in, dm_in, dq_in}),
    .dout(pin_s)
  );
  assign {ck_s, ca, odt_s, dqs_s, dm_s, dq_s} = pin_s;
  logic ck_d, dqs_d;
  logic ck_rise, dqs_edge;
  assign ck_rise = ck_s && !ck_d;
  assign dqs_edge = dqs_s != dqs_d;
  // edge history on synchronised levels
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      ck_d <= 1'b0;
      dqs_d <= 1'b0;
    end
    else if (clk_en)
    begin
      ck_d <= ck_s;
      dqs_d <= dqs_s;
    end
  ////////////////////////////////////////////////////////////////////////
  // cke history and decoding
  logic cke_prev;
  logic [31:0] mr [4];
  logic [7:0] bank_open;
  logic [3:0] beats_left;
  logic bursting, burst_wr;
  ddc_dec_t dec;
  ddc_decode u_dec (
    .ca(ca),
    .cke_prev(cke_prev),
    .otf_en(mr[0][1:0] == 2'h1),
    .fixed_bl8(mr[0][1:0] == 2'h0),
    .bursting(bursting),
    .dec(dec)
  );
  // cke registered on every rising ck edge
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      cke_prev <= 1'b0;
    else if (clk_en && ck_rise)
      cke_prev <= ca.cke;
  ////////////////////////////////////////////////////////////////////////
  // device state
  typedef enum logic [1:0] {DDC_ST_RUN, DDC_ST_PD, DDC_ST_SR} ddc_state_t;
  ddc_state_t state;
  logic all_idle;
  logic [3:0] last_cmd;
  logic [15:0] cmd_count;
  assign all_idle = bank_open == 8'h00;
  // power state transitions
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      state <= DDC_ST_RUN;
    else if (clk_en && ck_rise)
    begin
      unique case (state)
        DDC_ST_RUN:
          if (dec.cmd == DDC_CMD_PDE) state <= DDC_ST_PD;
          else if (dec.cmd == DDC_CMD_SRE && all_idle) state <= DDC_ST_SR;
        DDC_ST_PD, DDC_ST_SR:
          if (dec.cmd == DDC_CMD_PDX) state <= DDC_ST_RUN;
      endcase
    end
  // bank open bits
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      bank_open <= 8'h00;
    else if (clk_en && ck_rise && state == DDC_ST_RUN)
    begin
      unique case (dec.cmd)
        DDC_CMD_ACT: bank_open[dec.ba] <= 1'b1;
        DDC_CMD_PRE: bank_open[dec.ba] <= 1'b0;
        DDC_CMD_PREA: bank_open <= 8'h00;
        DDC_CMD_WR, DDC_CMD_RD:
          if (dec.ap && bank_open[dec.ba]) bank_open[dec.ba] <= 1'b0;
        default: ;
      endcase
    end
  // mode registers, written by mrs when idle or by the bus
  logic bus_wr;
  logic [11:0] bus_addr;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      for (int i = 0; i < 4; i++) mr[i] <= 32'h0;
    else if (clk_en)
    begin
      if (ck_rise && state == DDC_ST_RUN && dec.cmd == DDC_CMD_MRS && all_idle && dec.ba < 3'h4)
        mr[dec.ba[1:0]] <= {16'h0, dec.a};
      else if (bus_wr && bus_addr >= `DDC_REG_MR0 && bus_addr <= `DDC_REG_MR3)
        mr[bus_addr[3:2]] <= hwdata;
    end
  // last command and counter
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      last_cmd <= 4'h0;
      cmd_count <= 16'h0;
    end
    else if (clk_en && ck_rise && dec.cmd != DDC_CMD_DES && dec.cmd != DDC_CMD_NOP)
    begin
      last_cmd <= dec.cmd;
      cmd_count <= cmd_count + 16'h1;
    end
  ////////////////////////////////////////////////////////////////////////
  // burst data path
  logic tdqs_en, mask_en;
  logic [31:0] ctrl;
  logic [31:0] wdata;
  logic [7:0] wcount;
  assign tdqs_en = mr[1][`DDC_MR1_TDQS_BIT];
  assign mask_en = !tdqs_en;
  // burst start, beat counting on each strobe edge for writes, on each ck edge for reads
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      beats_left <= 4'h0;
      bursting <= 1'b0;
      burst_wr <= 1'b0;
    end
    else if (clk_en)
    begin
      if (ck_rise && state == DDC_ST_RUN && (dec.cmd == DDC_CMD_WR || dec.cmd == DDC_CMD_RD)
          && bank_open[dec.ba])
      begin
        beats_left <= dec.bl8 ? 4'(`DDC_BL8_BEATS) : 4'(`DDC_BC4_BEATS);
        bursting <= 1'b1;
        burst_wr <= dec.cmd == DDC_CMD_WR;
      end
      else if (ck_rise && dec.cmd == DDC_CMD_BST)
      begin
        beats_left <= 4'h0;
        bursting <= 1'b0;
      end
      else if (bursting && (burst_wr ? dqs_edge : ck_s != ck_d))
      begin
        beats_left <= beats_left - 4'h1;
        bursting <= beats_left != 4'h1;
      end
    end
  // write capture with mask
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      wdata <= 32'h0;
      wcount <= 8'h0;
    end
    else if (clk_en && bursting && burst_wr && dqs_edge && !(mask_en && dm_s))
    begin
      wdata <= {wdata[23:0], dq_s};
      wcount <= wcount + 8'h1;
    end
  // read drive: strobe toggles with each beat, data from the ctrl pattern
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      dq_out <= 8'h00;
      dq_oe <= 1'b0;
      dqs_out <= 1'b0;
      dqs_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      dq_oe <= bursting && !burst_wr;
      dqs_oe <= bursting && !burst_wr;
      if (bursting && !burst_wr && ck_s != ck_d)
      begin
        dqs_out <= !dqs_out;
        dq_out <= ctrl[7:0] + {4'h0, beats_left};
      end
      else if (!bursting)
        dqs_out <= 1'b0;
    end
  // termination control
  logic rtt_off;
  assign rtt_off = !(mr[1][`DDC_MR1_RTT0] || mr[1][`DDC_MR1_RTT1] || mr[1][`DDC_MR1_RTT2])
    && mr[2][`DDC_MR2_RTTWR_LSB +: 2] == 2'h0;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      term_on <= 1'b0;
      tdqs_term <= 1'b0;
    end
    else if (clk_en && ck_rise)
    begin
      term_on <= odt_s && !rtt_off && cke_prev;
      tdqs_term <= odt_s && !rtt_off && cke_prev && tdqs_en;
    end
  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states
  logic dphase_wr;
  assign bus_wr = dphase_wr;
  // address phase capture
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      dphase_wr <= 1'b0;
      bus_addr <= 12'h0;
    end
    else if (clk_en && hready)
    begin
      dphase_wr <= hsel && htrans[1] && hwrite;
      bus_addr <= haddr;
    end
  // ctrl register
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      ctrl <= `DDC_CTRL_RST;
    else if (clk_en && bus_wr && bus_addr == `DDC_REG_CTRL)
      ctrl <= hwdata;
  // read data registered at the address phase
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      hrdata <= 32'h0;
    else if (clk_en && hready && hsel && htrans[1] && !hwrite)
    begin
      unique case (haddr)
        `DDC_REG_STATUS: hrdata <= {24'h0, tdqs_term, term_on, bursting, burst_wr,
          cke_prev, 1'b0, state};
        `DDC_REG_BANKS: hrdata <= {24'h0, bank_open};
        `DDC_REG_LASTCMD: hrdata <= {12'h0, cmd_count, last_cmd};
        `DDC_REG_MR0: hrdata <= mr[0];
        `DDC_REG_MR1: hrdata <= mr[1];
        `DDC_REG_MR2: hrdata <= mr[2];
        `DDC_REG_MR3: hrdata <= mr[3];
        `DDC_REG_CTRL: hrdata <= ctrl;
        `DDC_REG_WDATA: hrdata <= wdata;
        `DDC_REG_WCOUNT: hrdata <= {24'h0, wcount};
        default: hrdata <= 32'h0;
      endcase
    end
  // always ready, always okay
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  ////////////////////////////////////////////////////////////////////////
  // assertions
  a_deselect_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && ck_rise && cke_prev && ca.cs_n && ca.cke |=> $stable(bank_open))
    else $error("deselect changed bank state");
  a_act_opens_bank: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && ck_rise && state == DDC_ST_RUN && dec.cmd == DDC_CMD_ACT
    |=> bank_open[$past(dec.ba)])
    else $error("activate did not open bank");
  a_prea_closes: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && ck_rise && state == DDC_ST_RUN && dec.cmd == DDC_CMD_PREA |=> bank_open == 8'h00)
    else $error("precharge all left a bank open");
  a_cke_low_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && ck_rise && !cke_prev |=> $stable(bank_open))
    else $error("command decoded with cke low");
  a_bc4_beats: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && ck_rise && state == DDC_ST_RUN && dec.cmd == DDC_CMD_WR && bank_open[dec.ba]
    && !dec.bl8 |=> beats_left == 4'h4)
    else $error("chopped burst not four beats");
  a_pd_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && ck_rise && state == DDC_ST_RUN && dec.cmd == DDC_CMD_PDE |=> state == DDC_ST_PD)
    else $error("power-down not entered");
  a_mask_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && bursting && burst_wr && dqs_edge && dm_s && mask_en |=> $stable(wcount))
    else $error("masked beat written");
  a_odt_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && ck_rise && rtt_off |=> !term_on && !tdqs_term)
    else $error("termination on while disabled");
  c_write_burst: cover property (@(posedge clk_sys) bursting && burst_wr);
  c_read_burst: cover property (@(posedge clk_sys) bursting && !burst_wr);
  c_self_refresh: cover property (@(posedge clk_sys) state == DDC_ST_SR);
endmodule

// ### verification/ddc_ctl_model.sv
// memory controller model driving the ddr3 command and data pins
`timescale 1ns/1ns
module ddc_ctl_model
  import ddc_pkg::*;
(
  // pins toward the device
  output logic ck,
  output ddc_ca_t ca_pin,
  output logic odt,
  output logic dqs_in,
  output logic [7:0] dq_in,
  output logic dm_in,
  // read drive seen from the device
  input wire logic dqs_out,
  input wire logic dqs_oe
);
  int rd_edges = 0;

  // free running memory clock, phase unrelated to clk_sys
  initial
  begin
    ck = 1'h0;
    ca_pin = {5'h1f, 3'h0, 16'h0000};
    odt = 1'h0;
    dqs_in = 1'h0;
    dq_in = 8'h00;
    dm_in = 1'h0;
    #137;
    forever #400 ck = ~ck;
  end

  ////////////////////////////////////////
  // one command around a rising ck edge, then deselect with lines inverted
  task automatic cmd(input logic [3:0] code, input logic cke, input logic [2:0] ba,
    input logic [15:0] a);
    @(negedge ck);
    ca_pin <= {code, cke, ba, a};
    @(negedge ck);
    ca_pin <= {1'h1, ~code[2:0], cke, ~ba, ~a};
  endtask

  // write beats s..e-1 of d, beat 0 in the top byte
  task automatic wr(input int s, input int e, input logic [63:0] d, input logic [7:0] m);
    for (int i = s; i < e; i++)
    begin
      dq_in = d[63-8*i -: 8];
      dm_in = m[7-i];
      #200 dqs_in = ~dqs_in;
      #200;
    end
    dq_in = ~dq_in;
    dm_in = ~dm_in;
  endtask

  // count read strobe edges while the device drives
  always @(dqs_out)
    if (dqs_oe)
      rd_edges++;
endmodule

// ### verification/ddr3_command_decoder_tb_top.sv
// self-checking bench for the ddr3 command decoder
`timescale 1ns/1ns
module ddr3_command_decoder_tb_top
  import ddc_pkg::*;
;
  typedef struct packed {
    logic [3:0] code;
    logic [2:0] ba;
    logic [15:0] a;
    logic [7:0] banks;
  } ddc_row_t;
  localparam logic [3:0] c_act = 4'h3;
  localparam logic [3:0] c_pre = 4'h2;
  localparam logic [3:0] c_wr = 4'h4;
  localparam logic [3:0] c_rd = 4'h5;
  localparam logic [3:0] c_mrs = 4'h0;
  localparam logic [3:0] c_ref = 4'h1;
  localparam logic [3:0] c_nop = 4'h7;
  localparam logic [3:0] c_zq = 4'h6;
  localparam logic [3:0] c_des = 4'hb;
  logic clk_sys, rst_n, clk_en, hsel, hwrite, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rdat;
  logic ck, odt, dqs_in, dm_in, dqs_out, dqs_oe, dq_oe, term_on, tdqs_term;
  logic [7:0] dq_in, dq_out;
  ddc_ca_t ca_pin;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  ddc_row_t rows [7];

  // device and controller model
  ddc_top dut_u (
    .clk_sys(clk_sys), .clk_en(clk_en), .rst_n(rst_n), .ck(ck), .ca_pin(ca_pin), .odt(odt),
    .dqs_in(dqs_in), .dq_in(dq_in), .dm_in(dm_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .dqs_out(dqs_out), .dqs_oe(dqs_oe), .term_on(term_on), .tdqs_term(tdqs_term),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp)
  );
  ddc_ctl_model ctl_u (
    .ck(ck), .ca_pin(ca_pin), .odt(odt), .dqs_in(dqs_in), .dq_in(dq_in), .dm_in(dm_in),
    .dqs_out(dqs_out), .dqs_oe(dqs_oe)
  );

  // 10 MHz system clock
  initial
  begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // single ahb-lite word transfer, read data into rdat
  task automatic bus(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    hsel <= 1'h1;
    haddr <= ad;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk_sys);
    while (hreadyout !== 1'h1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hreadyout !== 1'h1) @(posedge clk_sys);
    rdat = hrdata;
  endtask

  // let pin sampling settle, then read and compare masked bits
  task automatic rd(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] exp,
    input string what);
    repeat (12) @(posedge clk_sys);
    bus(1'h0, ad, 32'h0);
    chk(what, exp, rdat & m);
  endtask

  // hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end

  ////////////////////////////////////////
  initial
  begin
    rows = '{'{c_act, 3'h2, 16'h0000, 8'h04}, '{c_act, 3'h5, 16'h1234, 8'h24},
      '{c_des, 3'h1, 16'h0000, 8'h24}, '{c_pre, 3'h2, 16'h0000, 8'h20},
      '{c_act, 3'h0, 16'h0000, 8'h21}, '{c_pre, 3'h7, 16'h0400, 8'h00},
      '{c_zq, 3'h0, 16'h0400, 8'h00}};
    rst_n = 1'h0;
    clk_en = 1'h1;
    hsel = 1'h0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    rd(12'h100, 32'hffffffff, 32'h0, "unmapped");
    foreach (rows[i])
    begin
      ctl_u.cmd(rows[i].code, 1'h1, rows[i].ba, rows[i].a);
      rd(12'h004, 32'hff, {24'h0, rows[i].banks}, "bank_open");
    end
    rd(12'h008, 32'hf, 32'(DDC_CMD_ZQL), "last_cmd");
    $display("done command table");
    // mode register load and termination
    ctl_u.cmd(c_mrs, 1'h1, 3'h1, 16'h0044);
    rd(12'h014, 32'hffff, 32'h44, "mr1");
    ctl_u.odt <= 1'h1;
    rd(12'h000, 32'hc0, 32'h40, "term");
    bus(1'h1, 12'h014, 32'h0);
    bus(1'h1, 12'h018, 32'h0);
    rd(12'h000, 32'hc0, 32'h00, "term");
    bus(1'h1, 12'h014, 32'h0804);
    rd(12'h000, 32'hc0, 32'hc0, "term");
    $display("done termination");
    // writes: mask ignored with tdqs, then honoured
    bus(1'h1, 12'h010, 32'h1);
    ctl_u.cmd(c_act, 1'h1, 3'h1, 16'h0000);
    ctl_u.cmd(c_wr, 1'h1, 3'h1, 16'h0000);
    ctl_u.wr(0, 4, 64'hc1c2c3c4_00000000, 8'hf0);
    rd(12'h024, 32'hffffffff, 32'hc1c2c3c4, "wdata");
    rd(12'h028, 32'hffff, 32'h4, "wcount");
    rd(12'h000, 32'h20, 32'h00, "bursting");
    bus(1'h1, 12'h014, 32'h0);
    ctl_u.cmd(c_wr, 1'h1, 3'h1, 16'h0000);
    ctl_u.wr(0, 4, 64'hd1d2d3d4_00000000, 8'hf0);
    rd(12'h024, 32'hffffffff, 32'hc1c2c3c4, "wdata");
    ctl_u.cmd(c_wr, 1'h1, 3'h1, 16'h1400);
    ctl_u.wr(0, 4, 64'hb1b2b3b4_b5b6b7b8, 8'h04);
    rd(12'h000, 32'h30, 32'h30, "bursting");
    ctl_u.wr(4, 8, 64'hb1b2b3b4_b5b6b7b8, 8'h04);
    rd(12'h024, 32'hffffffff, 32'hb4b5b7b8, "wdata");
    rd(12'h004, 32'hff, 32'h00, "bank_open");
    $display("done writes");
    // reads: chopped then full with auto-precharge
    ctl_u.cmd(c_act, 1'h1, 3'h4, 16'h0000);
    @(posedge clk_sys);
    bus(1'h1, 12'h020, 32'h50);
    for (int k = 0; k < 2; k++)
    begin
      ctl_u.rd_edges = 0;
      ctl_u.cmd(c_rd, 1'h1, 3'h4, (k == 1) ? 16'h1400 : 16'h0000);
      wait (dqs_oe === 1'h1);
      chk("dq_oe", 32'h1, {31'h0, dq_oe});
      wait (dqs_oe === 1'h0);
      chk("read beats", (k == 1) ? 32'h8 : 32'h4, 32'(ctl_u.rd_edges));
      chk("read data", 32'h51, {24'h0, dq_out});
    end
    rd(12'h004, 32'hff, 32'h00, "bank_open");
    $display("done reads");
    // power-down and self-refresh
    ctl_u.cmd(c_nop, 1'h0, 3'h0, 16'h0000);
    rd(12'h000, 32'hb, 32'h1, "state");
    ctl_u.cmd(c_nop, 1'h1, 3'h0, 16'h0000);
    rd(12'h000, 32'hb, 32'h8, "state");
    ctl_u.cmd(c_ref, 1'h0, 3'h0, 16'h0000);
    rd(12'h000, 32'hb, 32'h2, "state");
    ctl_u.cmd(c_act, 1'h0, 3'h2, 16'h0000);
    rd(12'h004, 32'hff, 32'h00, "bank_open");
    ctl_u.cmd(c_des, 1'h1, 3'h0, 16'h0000);
    rd(12'h000, 32'hb, 32'h8, "state");
    ctl_u.cmd(c_ref, 1'h1, 3'h0, 16'h0000);
    rd(12'h000, 32'hb, 32'h8, "state");
    $display("done power states");
    // asynchronous reset in mid-run
    ctl_u.cmd(c_act, 1'h1, 3'h6, 16'h0000);
    rd(12'h004, 32'hff, 32'h40, "bank_open");
    // a command while the clock enable is low must be lost
    clk_en <= 1'h0;
    ctl_u.cmd(c_act, 1'h1, 3'h3, 16'h0000);
    clk_en <= 1'h1;
    rd(12'h004, 32'hff, 32'h40, "frozen");
    bus(1'h1, 12'h014, 32'h0004);
    repeat (12) @(posedge clk_sys);
    chk("term_on", 32'h1, {31'h0, term_on});
    rst_n <= 1'h0;
    #50;
    chk("term_on", 32'h0, {31'h0, term_on});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    chk("hresp", 32'h0, {31'h0, hresp});
    @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'h1;
    rd(12'h004, 32'hff, 32'h00, "bank_open");
    $display("done reset");
    end_of_test();
  end
endmodule
